// ===== verilog/css_host.sv
// Purpose: host sequencer writing the converter startup settings in order
// Assumes: apb slave, software sets link and cal fields then starts
// Notes: zero wait state apb; pready and prdata are registered
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: wait for stable device clock first
// RULE2: soft reset, then wait one microsecond
// RULE3: halt link before changing link settings
// RULE4: halt calibration before changing calibration settings
// RULE5: write link mode while both halted
// RULE6: write multiframe length minus one next
// RULE7: select sync source, single-ended or timestamp
// RULE8: write calibration mode and offset option
// RULE9: re-enable calibration after its settings
// RULE10: then enable overrange detection
// RULE11: restart link only after prior steps
// RULE12: link follows receiver sync request
// RULE13: trigger calibration by writing zero, one
// RULE14: steps strictly in order, one at once
module css_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clk_stable,
  css_cfg_if.host cfg
);
  typedef enum logic [2:0] {
    H_IDLE, H_CLK, H_ISSUE, H_ACK, H_RSTW, H_GAP
  } css_hst_type;

  localparam int RW = $clog2(css_pkg::SOFT_RESET_WAIT_CYC + 1);

  css_hst_type st_q;
  logic [3:0] step_q;
  logic [RW-1:0] wait_q;
  logic [31:0] link_q;
  logic [2:0] calc_q;
  logic busy_q, done_q, start_q;
  logic ck1_q, ck2_q;
  logic req_q;
  logic [css_pkg::ADDR_W-1:0] addr_q;
  logic [css_pkg::DATA_W-1:0] wdata_q;
  logic acc, wr_ok, rd_map;
  logic [11:0] k_sum;
  logic [css_pkg::ADDR_W-1:0] s_addr;
  logic [css_pkg::DATA_W-1:0] s_data;
  logic [31:0] rd_d;

  // ==========================================================
  // apb slave
  assign acc = psel && penable && pready;
  assign rd_map = paddr == css_pkg::APB_CTRL || paddr == css_pkg::APB_LINK
    || paddr == css_pkg::APB_CAL || paddr == css_pkg::APB_STAT;
  // settings are locked while the sequence runs
  assign wr_ok = rd_map && !(busy_q && paddr != css_pkg::APB_STAT);

  always_comb begin
    rd_d = 32'h0000_0000;
    case (paddr)
      css_pkg::APB_CTRL: rd_d = {31'h0000_0000, busy_q};
      css_pkg::APB_LINK: rd_d = link_q;
      css_pkg::APB_CAL: rd_d = {29'h0000_0000, calc_q};
      css_pkg::APB_STAT: rd_d = {24'h00_0000, step_q, 1'b0, ck2_q,
                                 done_q, busy_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr <= pwrite ? !wr_ok : !rd_map;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_q <= css_pkg::LINK_RESET;
      calc_q <= 3'h0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (acc && pwrite && wr_ok) begin
        case (paddr)
          css_pkg::APB_CTRL: start_q <= pwdata[0];
          css_pkg::APB_LINK: link_q <= pwdata;
          css_pkg::APB_CAL: calc_q <= pwdata[2:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // clock-stable strap, two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck1_q <= 1'b0;
      ck2_q <= 1'b0;
    end else begin
      ck1_q <= clk_stable;
      ck2_q <= ck1_q;
    end
  end

  // ==========================================================
  // step table; order is the startup order
  // k of zero is sent as k of 256 (km1 field wraps)
  assign k_sum = {4'h0, link_q[css_pkg::LINK_K_LSB +: 8]} - 12'h001;

  always_comb begin
    s_addr = css_pkg::DEV_SOFT_RESET;
    s_data = 8'h00;
    case (step_q)
      4'h0: begin
        s_addr = css_pkg::DEV_SOFT_RESET;  // [RULE2]
        s_data = 8'h01;
      end
      4'h1: s_addr = css_pkg::DEV_LINK_EN;  // [RULE3]
      4'h2: s_addr = css_pkg::DEV_CAL_EN;  // [RULE4]
      4'h3: begin
        s_addr = css_pkg::DEV_LINK_MODE;  // [RULE5]
        s_data = {3'h0, link_q[css_pkg::MODE_W-1:0]};
      end
      4'h4: begin
        s_addr = css_pkg::DEV_KM1;  // [RULE6]
        s_data = k_sum[7:0];
      end
      4'h5: begin
        s_addr = css_pkg::DEV_SYNC_SEL;  // [RULE7]
        s_data = {7'h00, link_q[css_pkg::LINK_SYNC_BIT]};
      end
      4'h6: begin
        s_addr = css_pkg::DEV_CAL_CFG;  // [RULE8]
        s_data = {6'h00, calc_q[1:0]};
      end
      4'h7: begin
        s_addr = css_pkg::DEV_CAL_EN;  // [RULE9]
        s_data = 8'h01;
      end
      4'h8: begin
        s_addr = css_pkg::DEV_OVERRANGE_ENABLE;  // [RULE10]
        s_data = {7'h00, calc_q[css_pkg::CAL_OVR_BIT]};
      end
      4'h9: begin
        s_addr = css_pkg::DEV_LINK_EN;  // [RULE11]
        s_data = 8'h01;
      end
      4'hA: s_addr = css_pkg::DEV_CAL_TRIG;  // [RULE13]
      4'hB: begin
        s_addr = css_pkg::DEV_CAL_TRIG;  // [RULE13]
        s_data = 8'h01;
      end
      default: ;
    endcase
  end

  // ==========================================================
  // sequencer: one write in flight, next only after its ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= H_IDLE;
      step_q <= 4'h0;
      wait_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      req_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (start_q) begin
            st_q <= H_CLK;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            step_q <= 4'h0;
          end
        end
        H_CLK: begin
          if (ck2_q) begin  // [RULE1]
            st_q <= H_ISSUE;
          end
        end
        H_ISSUE: begin
          req_q <= 1'b1;  // [RULE14]
          addr_q <= s_addr;
          wdata_q <= s_data;
          st_q <= H_ACK;
        end
        H_ACK: begin
          if (cfg.ack) begin  // [RULE14]
            req_q <= 1'b0;
            wait_q <= '0;
            st_q <= step_q == 4'h0 ? H_RSTW : H_GAP;
          end
        end
        H_RSTW: begin
          // counts from the ack, so the gap to the next write is longer
          wait_q <= wait_q + 1'b1;
          if (wait_q == RW'(css_pkg::SOFT_RESET_WAIT_CYC - 1)) begin
            st_q <= H_GAP;  // [RULE2]
          end
        end
        H_GAP: begin
          if (step_q == 4'(css_pkg::NUM_STEPS - 1)) begin
            st_q <= H_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            step_q <= step_q + 4'h1;  // [RULE14]
            st_q <= H_ISSUE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign cfg.req = req_q;
  assign cfg.addr = addr_q;
  assign cfg.wdata = wdata_q;
endmodule
`default_nettype wire

// ===== verilog/css_pkg.sv
// Purpose: shared constants for the converter startup sequencer ends
// Assumes: 10 MHz pclk, byte-wide device configuration port
// Notes: device port addresses and host apb offsets live here
package css_pkg;
  // ==========================================================
  // device configuration port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] DEV_SOFT_RESET = 4'h0;
  localparam logic [3:0] DEV_LINK_EN = 4'h1;
  localparam logic [3:0] DEV_CAL_EN = 4'h2;
  localparam logic [3:0] DEV_LINK_MODE = 4'h3;
  localparam logic [3:0] DEV_KM1 = 4'h4;
  localparam logic [3:0] DEV_SYNC_SEL = 4'h5;
  localparam logic [3:0] DEV_CAL_CFG = 4'h6;
  localparam logic [3:0] DEV_OVERRANGE_ENABLE = 4'h7;
  localparam logic [3:0] DEV_CAL_TRIG = 4'h8;
  localparam int MODE_W = 5;
  localparam logic [4:0] MODE_RESET = 5'h00;
  localparam logic [7:0] KM1_RESET = 8'h1F;
  localparam int CAL_BG_BIT = 0;
  localparam int CAL_OFS_BIT = 1;
  localparam int CAL_RUN_CYC = 64;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SOFT_RESET_WAIT_NS = 1000;
  localparam int SOFT_RESET_WAIT_CYC =
    (SOFT_RESET_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // host apb registers
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_LINK = 12'h004;
  localparam logic [11:0] APB_CAL = 12'h008;
  localparam logic [11:0] APB_STAT = 12'h00C;
  localparam int LINK_K_LSB = 8;
  localparam int LINK_SYNC_BIT = 16;
  localparam int CAL_OVR_BIT = 2;
  localparam logic [31:0] LINK_RESET = 32'h0000_2000;
  localparam int NUM_STEPS = 12;
endpackage

// ===== verilog/css_cfg_if.sv
// Purpose: configuration write port between host sequencer and device
// Assumes: one pclk shared by both ends
// Notes: req held until a one-cycle ack; req low at least two cycles between writes
`timescale 1ns/1ps
`default_nettype none
interface css_cfg_if;
  logic req;
  logic [css_pkg::ADDR_W-1:0] addr;
  logic [css_pkg::DATA_W-1:0] wdata;
  logic ack;
  modport host (output req, output addr, output wdata, input ack);
  modport dev (input req, input addr, input wdata, output ack);
endinterface
`default_nettype wire

// ===== verilog/css_device.sv
// Purpose: converter configuration registers, link and calibration fsms
// Assumes: sync pins asynchronous to pclk
// Notes: link settings locked while link runs, cal settings while cal runs
`timescale 1ns/1ps
`default_nettype none
module css_device #(
  parameter int CAL_RUN_CYC = css_pkg::CAL_RUN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  css_cfg_if.dev cfg,
  input wire logic sync_se_n,
  input wire logic ts_p,
  input wire logic ts_n,
  output logic [1:0] link_state,
  output logic link_valid,
  output logic cal_busy,
  output logic cal_done,
  output logic overrange_armed
);
  // the run counter is 16 bits wide, so longer runs cannot be served
  if (CAL_RUN_CYC < 1 || CAL_RUN_CYC > 65535) begin : g_bad_run
    $error("CAL_RUN_CYC out of range");
  end

  typedef enum logic [1:0] {LK_HALT, LK_SYNC, LK_ALIGN, LK_DATA} css_lk_type;
  typedef enum logic [1:0] {CL_IDLE, CL_RUN, CL_BG} css_cl_type;

  logic ack_q, wr;
  logic soft_q, link_en_q, cal_en_q, sync_sel_q, overrange_enable_q, trig_q;
  logic [css_pkg::MODE_W-1:0] mode_q;
  logic [7:0] km1_q;
  logic [1:0] cal_cfg_q;
  logic [2:0] s1_q, s2_q;
  logic sync_n;
  css_lk_type lk_q;
  css_cl_type cl_q;
  logic [7:0] frm_q;
  logic [15:0] cal_cnt_q;
  logic cal_start;

  // ==========================================================
  // configuration port
  assign wr = cfg.req && !ack_q;
  assign cfg.ack = ack_q;
  assign cal_start = wr && cfg.addr == css_pkg::DEV_CAL_TRIG
    && cfg.wdata[0] && !trig_q && cal_en_q;  // [RULE13]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wr;
    end
  end

  // soft reset returns every setting to default and self-clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_q <= 1'b0;
      link_en_q <= 1'b1;
      cal_en_q <= 1'b1;
      mode_q <= css_pkg::MODE_RESET;
      km1_q <= css_pkg::KM1_RESET;
      sync_sel_q <= 1'b0;
      cal_cfg_q <= 2'h0;
      overrange_enable_q <= 1'b0;
      trig_q <= 1'b0;
    end else if (soft_q) begin
      soft_q <= 1'b0;
      link_en_q <= 1'b1;
      cal_en_q <= 1'b1;
      mode_q <= css_pkg::MODE_RESET;
      km1_q <= css_pkg::KM1_RESET;
      sync_sel_q <= 1'b0;
      cal_cfg_q <= 2'h0;
      overrange_enable_q <= 1'b0;
      trig_q <= 1'b0;
    end else if (wr) begin
      case (cfg.addr)
        css_pkg::DEV_SOFT_RESET: soft_q <= cfg.wdata[0];
        css_pkg::DEV_LINK_EN: link_en_q <= cfg.wdata[0];  // [RULE3] [RULE11]
        css_pkg::DEV_CAL_EN: cal_en_q <= cfg.wdata[0];  // [RULE4] [RULE9]
        css_pkg::DEV_LINK_MODE: begin
          // mode changes both machines, so both must be halted
          if (!link_en_q && !cal_en_q) begin  // [RULE3] [RULE4]
            mode_q <= cfg.wdata[css_pkg::MODE_W-1:0];
          end
        end
        css_pkg::DEV_KM1: begin
          if (!link_en_q) begin  // [RULE3]
            km1_q <= cfg.wdata;
          end
        end
        css_pkg::DEV_SYNC_SEL: begin
          if (!link_en_q) begin  // [RULE3]
            sync_sel_q <= cfg.wdata[0];
          end
        end
        css_pkg::DEV_CAL_CFG: begin
          if (!cal_en_q) begin  // [RULE4]
            cal_cfg_q <= cfg.wdata[1:0];
          end
        end
        css_pkg::DEV_OVERRANGE_ENABLE: overrange_enable_q <= cfg.wdata[0];
        css_pkg::DEV_CAL_TRIG: trig_q <= cfg.wdata[0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // sync pins: two flops each before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 3'h1;
      s2_q <= 3'h1;
    end else begin
      s1_q <= {ts_n, ts_p, sync_se_n};
      s2_q <= s1_q;
    end
  end
  // timestamp pair requests sync when n is above p
  assign sync_n = sync_sel_q ? !(s2_q[2] && !s2_q[1]) : s2_q[0];

  // ==========================================================
  // link fsm follows the receiver's sync request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk_q <= LK_HALT;
      frm_q <= 8'h00;
    end else if (!link_en_q || soft_q) begin
      lk_q <= LK_HALT;
      frm_q <= 8'h00;
    end else begin
      case (lk_q)
        LK_HALT: lk_q <= LK_SYNC;
        LK_SYNC: begin
          frm_q <= 8'h00;
          if (sync_n) begin  // [RULE12]
            lk_q <= LK_ALIGN;
          end
        end
        LK_ALIGN: begin
          frm_q <= frm_q + 8'h01;
          if (!sync_n) begin  // [RULE12]
            lk_q <= LK_SYNC;
          end else if (frm_q == km1_q) begin
            lk_q <= LK_DATA;
          end
        end
        LK_DATA: begin
          if (!sync_n) begin  // [RULE12]
            lk_q <= LK_SYNC;
          end
        end
        default: lk_q <= LK_HALT;
      endcase
    end
  end

  // ==========================================================
  // calibration fsm; disabling it aborts a run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl_q <= CL_IDLE;
      cal_cnt_q <= 16'h0000;
      cal_done <= 1'b0;
    end else if (!cal_en_q || soft_q) begin  // [RULE4]
      cl_q <= CL_IDLE;
      cal_cnt_q <= 16'h0000;
    end else begin
      case (cl_q)
        CL_IDLE: begin
          if (cal_start) begin  // [RULE13]
            cl_q <= CL_RUN;
            cal_cnt_q <= 16'h0000;
            cal_done <= 1'b0;
          end
        end
        CL_RUN: begin
          cal_cnt_q <= cal_cnt_q + 16'h0001;
          if (cal_cnt_q == 16'(CAL_RUN_CYC - 1)) begin
            cal_done <= 1'b1;
            cl_q <= cal_cfg_q[css_pkg::CAL_BG_BIT] ? CL_BG : CL_IDLE;
          end
        end
        CL_BG: cl_q <= CL_BG;
        default: cl_q <= CL_IDLE;
      endcase
    end
  end

  // ==========================================================
  // status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_state <= 2'h0;
      link_valid <= 1'b0;
      cal_busy <= 1'b0;
      overrange_armed <= 1'b0;
    end else begin
      link_state <= lk_q;
      link_valid <= lk_q == LK_DATA;
      cal_busy <= cl_q != CL_IDLE;
      overrange_armed <= overrange_enable_q && cal_en_q;
    end
  end
endmodule
`default_nettype wire

// ===== verification/css_cfg_asserts.sv
// Purpose: checks on the cfg write port between host and device
// Assumes: one pclk, presetn async active low
// Notes: watches only the interface signals
`timescale 1ns/1ps
`default_nettype none
module css_cfg_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [css_pkg::ADDR_W-1:0] addr,
  input wire logic [css_pkg::DATA_W-1:0] wdata,
  input wire logic ack
);
  logic [11:0] last_q;
  // ==========================================================
  // last accepted write, so each new request can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 12'h000;
    end else if (ack) begin
      last_q <= {addr, wdata};
    end
  end
  // ==========================================================
  // handshake and order
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_HOLD: assert property (
    req && !ack |=> ack && req && $stable({addr, wdata}))
    else $error("cfg request not acked or changed while pending");
  AST_RELEASE: assert property (
    ack |=> !ack && !req)
    else $error("cfg ack or request stood too long");
  AST_RESET_WAIT: assert property (
    ack && addr == css_pkg::DEV_SOFT_RESET |=> !req [*8] ##1 !req [*2])
    else $error("write too soon after soft reset");
  AST_LINK_HALT: assert property (
    $rose(req) && last_q == {css_pkg::DEV_SOFT_RESET, 8'h01}
    |-> addr == css_pkg::DEV_LINK_EN && wdata == 8'h00)
    else $error("link not halted after soft reset");
  AST_CAL_HALT: assert property (
    $rose(req) && last_q == {css_pkg::DEV_LINK_EN, 8'h00}
    |-> addr == css_pkg::DEV_CAL_EN && wdata == 8'h00)
    else $error("calibration not halted after link halt");
  AST_MODE: assert property (
    $rose(req) && last_q == {css_pkg::DEV_CAL_EN, 8'h00}
    |-> addr == css_pkg::DEV_LINK_MODE)
    else $error("link mode not written after both halted");
  AST_CAL_ON: assert property (
    $rose(req) && last_q[11:8] == css_pkg::DEV_CAL_CFG
    |-> addr == css_pkg::DEV_CAL_EN && wdata == 8'h01)
    else $error("calibration not enabled after its settings");
  AST_LINK_ON: assert property (
    $rose(req) && last_q[11:8] == css_pkg::DEV_OVERRANGE_ENABLE
    |-> addr == css_pkg::DEV_LINK_EN && wdata == 8'h01)
    else $error("link not restarted after overrange step");
  AST_TRIG: assert property (
    $rose(req) && last_q == {css_pkg::DEV_CAL_TRIG, 8'h00}
    |-> addr == css_pkg::DEV_CAL_TRIG && wdata == 8'h01)
    else $error("trigger zero not followed by trigger one");
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Purpose: host and device back to back, apb driven startup runs
// Assumes: 10 MHz pclk, short calibration run of 4 cycles
// Notes: expected write list built from the startup order
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, clk_stable;
  logic sync_se_n, ts_p, ts_n, pready, pslverr, err;
  logic link_valid, cal_busy, cal_done, overrange_armed;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] link_state;
  logic [11:0] obs_q[$];
  logic [11:0] exp_q[$];
  int failures, checks_done;
  css_cfg_if css_cfg_if_i ();
  css_host css_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clk_stable(clk_stable), .cfg(css_cfg_if_i));
  css_device #(.CAL_RUN_CYC(4)) css_device_i (.pclk(pclk),
    .presetn(presetn), .cfg(css_cfg_if_i), .sync_se_n(sync_se_n),
    .ts_p(ts_p), .ts_n(ts_n), .link_state(link_state),
    .link_valid(link_valid), .cal_busy(cal_busy), .cal_done(cal_done),
    .overrange_armed(overrange_armed));
  css_cfg_asserts css_cfg_asserts_i (.pclk(pclk), .presetn(presetn),
    .req(css_cfg_if_i.req), .addr(css_cfg_if_i.addr),
    .wdata(css_cfg_if_i.wdata), .ack(css_cfg_if_i.ack));
  // ==========================================================
  // clock and write monitor; ack stands one cycle, so mid-cycle is safe
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(negedge pclk) begin
    if (css_cfg_if_i.ack === 1'b1) begin
      obs_q.push_back({css_cfg_if_i.addr, css_cfg_if_i.wdata});
    end
  end
  // ==========================================================
  // compare, bus and closing tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cfg(input logic [11:0] got, input logic [11:0] exp);
    chk_val({20'h0, got}, {20'h0, exp});
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready, prdata and pslverr are read at the access edge itself
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // one full startup run with the given settings
  task automatic run_seq(input logic [7:0] k, input logic [4:0] mode,
      input logic sel, input logic [2:0] cal);
    logic [7:0] km1;
    km1 = k - 8'h01;
    exp_q = '{{css_pkg::DEV_SOFT_RESET, 8'h01},
      {css_pkg::DEV_LINK_EN, 8'h00}, {css_pkg::DEV_CAL_EN, 8'h00},
      {css_pkg::DEV_LINK_MODE, 3'h0, mode}, {css_pkg::DEV_KM1, km1},
      {css_pkg::DEV_SYNC_SEL, 7'h0, sel},
      {css_pkg::DEV_CAL_CFG, 6'h0, cal[1:0]},
      {css_pkg::DEV_CAL_EN, 8'h01}, {css_pkg::DEV_OVERRANGE_ENABLE, 7'h0, cal[2]},
      {css_pkg::DEV_LINK_EN, 8'h01}, {css_pkg::DEV_CAL_TRIG, 8'h00},
      {css_pkg::DEV_CAL_TRIG, 8'h01}};
    obs_q.delete();
    apb(1'b1, css_pkg::APB_LINK, {15'h0, sel, k, 3'h0, mode});
    apb(1'b1, css_pkg::APB_CAL, {29'h0, cal});
    apb(1'b1, css_pkg::APB_CTRL, 32'h0000_0001);
    apb(1'b1, css_pkg::APB_LINK, 32'h0000_0000);
    chk_val({31'h0, err}, 32'h0000_0001);
    if (clk_stable !== 1'b1) begin
      repeat (30) @(posedge pclk);
      chk_val(obs_q.size(), 32'h0000_0000);
      clk_stable <= 1'b1;
    end
    repeat (300) begin
      apb(1'b0, css_pkg::APB_STAT, 32'h0000_0000);
      if (rd[1] === 1'b1) break;
    end
    chk_val(rd & 32'h0000_0007, 32'h0000_0006);
    chk_val(obs_q.size(), 32'h0000_000C);
    foreach (exp_q[i]) chk_cfg(obs_q[i], exp_q[i]);
    repeat (10) @(posedge pclk);
    chk_val({31'h0, overrange_armed}, {31'h0, cal[2]});
    // background mode keeps running, foreground ends with done
    chk_val({31'h0, cal[0] ? cal_busy : cal_done}, 32'h1);
    ts_p <= !sel;
    ts_n <= sel;
    sync_se_n <= sel;
    repeat (8) @(posedge pclk);
    chk_val({30'h0, link_state}, 32'h0000_0001);
    ts_p <= 1'b1;
    ts_n <= 1'b0;
    sync_se_n <= 1'b1;
    repeat (km1 + 12) @(posedge pclk);
    chk_val({31'h0, link_valid}, 32'h0000_0001);
    $display("test k=%h mode=%h sel=%b cal=%h done", k, mode, sel, cal);
  endtask
  // ==========================================================
  // main sequence and watchdog, sized well above three runs
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    clk_stable = 1'b0;
    sync_se_n = 1'b1;
    ts_p = 1'b1;
    ts_n = 1'b0;
    void'($urandom(32'hEE24));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, css_pkg::APB_LINK, 32'h0000_0000);
    chk_val(rd, css_pkg::LINK_RESET);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk_val({err, rd[30:0]}, 32'h8000_0000);
    $display("test registers done");
    run_seq(8'h00, 5'($urandom), 1'($urandom), 3'($urandom));
    run_seq(8'h01, 5'($urandom), 1'($urandom), 3'($urandom));
    run_seq(8'($urandom), 5'($urandom), 1'($urandom), 3'($urandom));
    wrap_up();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
